// *** verilog/uart_defs.svh ***
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH
`define OVERSAMPLE        5'd16
`define START_WAIT        4'd7
`define AUTO_SAMPLE_POS   4'd7
`define BREAK_BITS        4'd10
`define FMT_7BIT          2'd0
`define FMT_8BIT          2'd1
`define FMT_9BIT          2'd2
`define PSC_RESET         5'h00
`define DIV_RESET         11'h000
`endif

// *** verilog/uart_pkg.sv ***
`default_nettype none
package uart_pkg;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_STOP  = 3'b011,
    RX_BREAK = 3'b100
  } rx_state_t;
endpackage : uart_pkg
`default_nettype wire

// *** verilog/baud_gen.sv ***
`include "uart_defs.svh"
`default_nettype none
// prescaler counts in half steps: factor = (psc+1)/2, zero stops the clock
module baud_gen (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // settings
  input  wire logic [4:0]  prescale_sel,
  input  wire logic [10:0] baud_div,
  // 16x tick
  output logic             os_tick
);
  logic [5:0]  psc_acc_reg;
  logic [10:0] div_cnt_reg;
  logic        psc_tick;
  logic [5:0]  psc_sum;

  assign psc_sum  = psc_acc_reg + 6'd2;
  assign psc_tick = (prescale_sel != 5'h00) &&
                    (psc_sum > {1'b0, prescale_sel});

  // first stage, fractional prescaler
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      psc_acc_reg <= 6'h00;
    end else if (prescale_sel == 5'h00) begin
      psc_acc_reg <= 6'h00;
    end else if (psc_tick) begin
      psc_acc_reg <= psc_sum - {1'b0, prescale_sel} - 6'd1;
    end else begin
      psc_acc_reg <= psc_sum;
    end
  end

  // second stage, divide by divisor + 1
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= 11'h000;
      os_tick     <= 1'b0;
    end else begin
      os_tick <= 1'b0;
      if (psc_tick) begin
        if (div_cnt_reg >= baud_div) begin
          div_cnt_reg <= 11'h000;
          os_tick     <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 11'h001;
        end
      end
    end
  end
endmodule : baud_gen
`default_nettype wire

// *** verilog/bit_sync.sv ***
`default_nettype none
module bit_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b1;
      dout     <= 1'b1;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : bit_sync
`default_nettype wire

// *** verilog/async_serial_transceiver.sv ***
`include "uart_defs.svh"
`default_nettype none
module async_serial_transceiver (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // serial pins, flow control active low
  output logic             txd,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  output logic             rts_n,
  // configuration
  input  wire logic [4:0]  prescale_sel,
  input  wire logic [10:0] baud_div,
  input  wire logic [1:0]  frame_format,
  input  wire logic        parity_enable,
  input  wire logic        parity_odd,
  input  wire logic        two_stop_bits,
  input  wire logic        attention_mode,
  input  wire logic        diagnostic_mode,
  input  wire logic        flow_ctrl_enable,
  input  wire logic        manual_sample_mode,
  input  wire logic [3:0]  sample_position_reg,
  input  wire logic        tx_irq_enable,
  // transmit side
  input  wire logic        tx_write,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_ninth_bit,
  output logic             tx_buffer_empty_flag,
  output logic             tx_in_progress_flag,
  output logic             tx_irq,
  // receive side
  input  wire logic        rx_read,
  output logic [7:0]       rx_holding_buffer,
  output logic             rx_ninth_bit,
  output logic             rx_buffer_full_flag,
  input  wire logic        address_wait_set,
  output logic             address_wait_bit,
  input  wire logic        err_clear,
  output logic             framing_error,
  output logic             parity_error,
  output logic             overrun_error,
  output logic             break_detect
);
  logic os_tick;
  logic rxd_sync;
  logic cts_n_sync;
  logic rx_line;
  logic nine_bit;
  logic par_on;
  logic [3:0] nbits;
  logic [3:0] samp_pos;

  function automatic logic [3:0] data_bits(input logic [1:0] f);
    case (f)
      `FMT_7BIT: data_bits = 4'd7;
      `FMT_8BIT: data_bits = 4'd8;
      default:   data_bits = 4'd9;
    endcase
  endfunction : data_bits

  // attention and diagnostic force nine bits, no parity
  assign nine_bit = (frame_format == `FMT_9BIT) || attention_mode ||
                    diagnostic_mode;
  assign nbits  = nine_bit ? 4'd9 : data_bits(frame_format);
  assign par_on = parity_enable && !nine_bit;
  assign samp_pos = manual_sample_mode ? sample_position_reg
                                       : `AUTO_SAMPLE_POS;

  baud_gen u_baud (
    .clk          (clk),
    .arst_n       (arst_n),
    .prescale_sel (prescale_sel),
    .baud_div     (baud_div),
    .os_tick      (os_tick)
  );
  bit_sync u_rxd_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (rxd),
    .dout   (rxd_sync)
  );
  bit_sync u_cts_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (cts_n),
    .dout   (cts_n_sync)
  );

  // ---------------- transmitter
  uart_pkg::tx_state_t tx_state_reg;
  logic [7:0] tx_holding_buffer;
  logic       tx_b9_hold_reg;
  logic [7:0] tx_shift_reg;
  logic       tx_b9_reg;
  logic       tx_par_reg;
  logic [3:0] tx_os_reg;
  logic [3:0] tx_bit_reg;
  logic       tx_bit_end;
  logic       tx_may_start;

  assign tx_bit_end   = os_tick && (tx_os_reg == 4'hf);
  assign tx_may_start = !tx_buffer_empty_flag &&
                        !(flow_ctrl_enable && cts_n_sync);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_holding_buffer <= 8'h00;
      tx_b9_hold_reg    <= 1'b0;
    end else if (tx_write) begin
      tx_holding_buffer <= tx_data;
      tx_b9_hold_reg    <= tx_ninth_bit;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_reg         <= uart_pkg::TX_IDLE;
      tx_buffer_empty_flag <= 1'b1;
      tx_shift_reg         <= 8'h00;
      tx_b9_reg            <= 1'b0;
      tx_par_reg           <= 1'b0;
      tx_os_reg            <= 4'h0;
      tx_bit_reg           <= 4'h0;
      txd                  <= 1'b1;
    end else begin
      if (tx_write) begin
        tx_buffer_empty_flag <= 1'b0;
      end
      if (os_tick) begin
        tx_os_reg <= tx_os_reg + 4'h1;
      end
      case (tx_state_reg)
        uart_pkg::TX_IDLE: begin
          txd <= 1'b1;
          if (tx_may_start && !tx_write) begin
            // parallel load, buffer now free again
            tx_shift_reg         <= tx_holding_buffer;
            tx_b9_reg            <= tx_b9_hold_reg;
            tx_par_reg           <= parity_odd;
            tx_buffer_empty_flag <= 1'b1;
            tx_os_reg            <= 4'h0;
            tx_state_reg         <= uart_pkg::TX_START;
            txd                  <= 1'b0;
          end
        end
        uart_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_bit_reg   <= 4'h0;
            tx_state_reg <= uart_pkg::TX_DATA;
            txd          <= tx_shift_reg[0];
          end
        end
        uart_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            if (tx_bit_reg < nbits - 4'd1) begin
              tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
              // lsb first, ninth bit follows bit 7
              tx_shift_reg <= {tx_b9_reg, tx_shift_reg[7:1]};
              txd          <= (tx_bit_reg == 4'd7) ? tx_b9_reg
                                                   : tx_shift_reg[1];
              tx_bit_reg   <= tx_bit_reg + 4'h1;
            end else if (par_on && tx_bit_reg == nbits - 4'd1) begin
              txd        <= tx_par_reg ^ tx_shift_reg[0];
              tx_bit_reg <= tx_bit_reg + 4'h1;
            end else begin
              tx_bit_reg   <= 4'h0;
              tx_state_reg <= uart_pkg::TX_STOP;
              txd          <= 1'b1;
            end
          end
        end
        uart_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            if (two_stop_bits && tx_bit_reg == 4'h0) begin
              tx_bit_reg <= 4'h1;
            end else begin
              tx_state_reg <= uart_pkg::TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= uart_pkg::TX_IDLE;
      endcase
    end
  end

  assign tx_in_progress_flag = (tx_state_reg != uart_pkg::TX_IDLE) ||
                               !tx_buffer_empty_flag;
  assign tx_irq = tx_buffer_empty_flag && tx_irq_enable;
  assign rts_n  = !(flow_ctrl_enable && !tx_buffer_empty_flag);

  // ---------------- receiver
  uart_pkg::rx_state_t rx_state_reg;
  logic [8:0] rx_shift_reg;
  logic [3:0] rx_os_reg;
  logic [3:0] rx_bit_reg;
  logic [2:0] rx_samp_reg;
  logic       rx_par_reg;
  logic       rx_vote;
  logic       rx_samp_now;
  logic [3:0] rx_brk_reg;
  logic [8:0] rx_char;

  assign rx_line = diagnostic_mode ? txd : rxd_sync;
  assign rx_vote = (rx_samp_reg[0] & rx_samp_reg[1]) |
                   (rx_samp_reg[1] & rx_samp_reg[2]) |
                   (rx_samp_reg[0] & rx_samp_reg[2]);
  // three samples centred on the chosen position
  assign rx_samp_now = os_tick && (rx_os_reg >= samp_pos - 4'd1) &&
                       (rx_os_reg <= samp_pos + 4'd1);
  // character as received, ninth bit in top position
  assign rx_char = (nbits == 4'd9) ? rx_shift_reg :
                   (nbits == 4'd8) ? {1'b0, rx_shift_reg[8:1]} :
                                     {2'b00, rx_shift_reg[8:2]};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_reg        <= uart_pkg::RX_IDLE;
      rx_shift_reg        <= 9'h000;
      rx_os_reg           <= 4'h0;
      rx_bit_reg          <= 4'h0;
      rx_samp_reg         <= 3'h7;
      rx_par_reg          <= 1'b0;
      rx_brk_reg          <= 4'h0;
      rx_holding_buffer   <= 8'h00;
      rx_ninth_bit        <= 1'b0;
      rx_buffer_full_flag <= 1'b0;
      address_wait_bit    <= 1'b0;
      framing_error       <= 1'b0;
      parity_error        <= 1'b0;
      overrun_error       <= 1'b0;
      break_detect        <= 1'b0;
    end else begin
      // clears and the address wait set first so that a same-cycle receiver update wins
      if (rx_read) begin
        rx_buffer_full_flag <= 1'b0;
      end
      if (address_wait_set) begin
        address_wait_bit <= 1'b1;
      end
      if (err_clear) begin
        framing_error <= 1'b0;
        parity_error  <= 1'b0;
        overrun_error <= 1'b0;
        break_detect  <= 1'b0;
      end
      if (os_tick) begin
        rx_os_reg <= rx_os_reg + 4'h1;
      end
      if (rx_samp_now) begin
        rx_samp_reg <= {rx_samp_reg[1:0], rx_line};
      end
      case (rx_state_reg)
        uart_pkg::RX_IDLE: begin
          rx_os_reg <= 4'h0;
          if (os_tick && !rx_line) begin
            rx_samp_reg  <= 3'h7;
            rx_state_reg <= uart_pkg::RX_START;
          end
        end
        uart_pkg::RX_START: begin
          // seven oversample ticks after the low, then three samples
          if (os_tick && rx_os_reg >= `START_WAIT - 4'd1 &&
              rx_os_reg <= `START_WAIT + 4'd1) begin
            rx_samp_reg <= {rx_samp_reg[1:0], rx_line};
            if (rx_line) begin
              rx_state_reg <= uart_pkg::RX_IDLE;
            end
          end
          if (os_tick && rx_os_reg == 4'hf) begin
            rx_bit_reg   <= 4'h0;
            rx_par_reg   <= parity_odd;
            rx_state_reg <= uart_pkg::RX_DATA;
          end
        end
        uart_pkg::RX_DATA: begin
          if (os_tick && rx_os_reg == 4'hf) begin
            if (rx_bit_reg < nbits) begin
              rx_shift_reg <= {rx_vote, rx_shift_reg[8:1]};
              rx_par_reg   <= rx_par_reg ^ rx_vote;
              rx_bit_reg   <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == nbits - 4'd1 && !par_on) begin
                rx_state_reg <= uart_pkg::RX_STOP;
              end
            end else begin
              if (rx_par_reg != rx_vote) begin
                parity_error <= 1'b1;
              end
              rx_state_reg <= uart_pkg::RX_STOP;
            end
          end
        end
        uart_pkg::RX_STOP: begin
          if (os_tick && rx_os_reg == samp_pos + 4'd2) begin
            rx_state_reg <= uart_pkg::RX_IDLE;
            if (!rx_vote) begin
              framing_error <= 1'b1;
              rx_brk_reg    <= 4'h0;
              rx_state_reg  <= uart_pkg::RX_BREAK;
            end
            if (!attention_mode || !address_wait_bit || rx_char[8]) begin
              if (rx_buffer_full_flag && !rx_read) begin
                overrun_error <= 1'b1;
              end
              rx_holding_buffer   <= rx_char[7:0];
              rx_ninth_bit        <= rx_char[8];
              rx_buffer_full_flag <= 1'b1;
              if (attention_mode && address_wait_bit) begin
                address_wait_bit <= 1'b0;
              end
            end
          end
        end
        uart_pkg::RX_BREAK: begin
          if (rx_line) begin
            rx_state_reg <= uart_pkg::RX_IDLE;
          end else if (os_tick && rx_os_reg == 4'hf) begin
            if (rx_brk_reg == `BREAK_BITS - 4'd1) begin
              break_detect <= 1'b1;
            end else begin
              rx_brk_reg <= rx_brk_reg + 4'h1;
            end
          end
        end
        default: rx_state_reg <= uart_pkg::RX_IDLE;
      endcase
    end
  end
endmodule : async_serial_transceiver
`default_nettype wire

// *** tb/uart_check_assertions.sv ***
`default_nettype none
module uart_check (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // pins and settings
  input wire logic        txd,
  input wire logic        rts_n,
  input wire logic [4:0]  prescale_sel,
  input wire logic [10:0] baud_div,
  input wire logic [1:0]  frame_format,
  input wire logic        attention_mode,
  input wire logic        diagnostic_mode,
  input wire logic        flow_ctrl_enable,
  input wire logic        tx_irq_enable,
  // transmit side
  input wire logic        tx_write,
  input wire logic        tx_buffer_empty_flag,
  input wire logic        tx_in_progress_flag,
  input wire logic        tx_irq,
  // receive side
  input wire logic        rx_read,
  input wire logic        rx_ninth_bit,
  input wire logic        rx_buffer_full_flag,
  input wire logic        address_wait_set,
  input wire logic        address_wait_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic fast = prescale_sel == 5'h01 && baud_div == 11'h000;
  wire logic got = rx_buffer_full_flag;
  // one bit time at one tick per clock
  sequence start_bit; !txd [*8] ##1 !txd [*8]; endsequence
  sequence addr_taken; rx_ninth_bit ##1 !address_wait_bit; endsequence
  irq_level_a: assert property (tx_irq == (tx_buffer_empty_flag && tx_irq_enable))
    else $error("tx irq level wrong");
  write_clears_a: assert property (tx_write |=> !tx_buffer_empty_flag)
    else $error("empty flag not cleared by write");
  load_start_a: assert property ($rose(tx_buffer_empty_flag) && !diagnostic_mode |-> !txd)
    else $error("reload without start bit");
  busy_hold_a: assert property (!tx_buffer_empty_flag |-> tx_in_progress_flag)
    else $error("busy low with buffer loaded");
  start_len_a: assert property ($fell(txd) && fast |-> start_bit)
    else $error("start bit not sixteen clocks");
  rts_level_a: assert property (rts_n == !(flow_ctrl_enable && !tx_buffer_empty_flag))
    else $error("rts level wrong");
  read_clears_a: assert property (rx_read |=> !got)
    else $error("full flag not cleared by read");
  addr_accept_a: assert property ($rose(got) && attention_mode && $past(address_wait_bit) |-> addr_taken)
    else $error("attention accepted non address");
  arm_wait_a: assert property (address_wait_set |=> address_wait_bit)
    else $error("address wait not set");
  ninth_zero_a: assert property ($rose(got) && frame_format[1] == 1'b0 && !diagnostic_mode && !attention_mode |-> !rx_ninth_bit)
    else $error("ninth bit set in short format");
endmodule : uart_check
bind async_serial_transceiver uart_check u_chk (.clk(clk), .arst_n(arst_n),
  .txd(txd), .rts_n(rts_n), .prescale_sel(prescale_sel), .baud_div(baud_div),
  .frame_format(frame_format), .attention_mode(attention_mode),
  .diagnostic_mode(diagnostic_mode), .flow_ctrl_enable(flow_ctrl_enable),
  .tx_irq_enable(tx_irq_enable), .tx_write(tx_write),
  .tx_buffer_empty_flag(tx_buffer_empty_flag), .tx_irq(tx_irq),
  .tx_in_progress_flag(tx_in_progress_flag), .rx_read(rx_read),
  .rx_ninth_bit(rx_ninth_bit), .rx_buffer_full_flag(rx_buffer_full_flag),
  .address_wait_set(address_wait_set), .address_wait_bit(address_wait_bit));
`default_nettype wire

// *** tb/serial_peer.sv ***
`default_nettype none
module serial_peer (
  // clock
  input  wire logic clk,
  // serial lines
  input  wire logic txd,
  output logic      rxd,
  output logic      cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  task automatic hold(input logic v);
    cts_n = v;
  endtask : hold
  // start low for len clocks, then n bits lsb first, line idles high
  task automatic send(input logic [11:0] bits, input int n, input int len);
    @(negedge clk);
    rxd = 1'b0;
    repeat (len) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      rxd = bits[i];
      repeat (16) @(negedge clk);
    end
    rxd = 1'b1;
  endtask : send
  task automatic recv(output logic [11:0] bits, input int n);
    int t;
    t = 0;
    bits = 12'h000;
    // txd launches on the rising edge, so look at it on the falling one
    while (txd !== 1'b0 && t < 4000) begin
      @(negedge clk);
      t++;
    end
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(negedge clk);
      bits[i] = txd;
    end
  endtask : recv
endmodule : serial_peer
`default_nettype wire

// *** tb/test_async_serial_transceiver.sv ***
`default_nettype none
module test_async_serial_transceiver;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n, txd, rxd, cts_n, rts_n, par, odd, stop2, atn, diag, flow;
  logic msm, irq_en, tx_write, b9, rx_read, aws, err_clr, empty, busy;
  logic irq, r9, full, awb, fe, pe, oe, brk;
  logic [4:0]  psc;
  logic [10:0] div;
  logic [1:0]  fmt;
  logic [3:0]  spos;
  logic [7:0]  tx_data, rbuf, d;
  logic [11:0] got, expq[$];
  logic [4:0]  cfg [4] = '{5'h04, 5'h0f, 5'h09, 5'h10};
  int nq[$], errors, num_checks, cycles, pos;
  int seed = 32'h0c5b240d;
  async_serial_transceiver dut (.clk(clk), .arst_n(arst_n), .txd(txd),
    .rxd(rxd), .cts_n(cts_n), .rts_n(rts_n), .prescale_sel(psc),
    .baud_div(div), .frame_format(fmt), .parity_enable(par),
    .parity_odd(odd), .two_stop_bits(stop2), .attention_mode(atn),
    .diagnostic_mode(diag), .flow_ctrl_enable(flow),
    .manual_sample_mode(msm), .sample_position_reg(spos),
    .tx_irq_enable(irq_en), .tx_write(tx_write), .tx_data(tx_data),
    .tx_ninth_bit(b9), .tx_buffer_empty_flag(empty),
    .tx_in_progress_flag(busy), .tx_irq(irq), .rx_read(rx_read),
    .rx_holding_buffer(rbuf), .rx_ninth_bit(r9), .rx_buffer_full_flag(full),
    .address_wait_set(aws), .address_wait_bit(awb), .err_clear(err_clr),
    .framing_error(fe), .parity_error(pe), .overrun_error(oe),
    .break_detect(brk));
  serial_peer u_peer (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      close_out;
    end
  end
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [11:0] g, input logic [11:0] e, string w);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, w, g, e);
    end
  endtask : chk
  // frame after the start bit: data, ninth or parity, stops
  task automatic build(input logic [7:0] v, input logic n9,
                       output logic [11:0] f, output int n);
    n = (fmt == 2'd0) ? 7 : 8;
    f = 12'h000;
    for (int i = 0; i < n; i++) f[i] = v[i];
    if (fmt[1]) f[n++] = n9;
    else if (par) f[n++] = ^(f[7:0]) ^ odd;
    f[n++] = 1'b1;
    if (stop2) f[n++] = 1'b1;
  endtask : build
  task automatic wr(input logic [7:0] v, input logic n9);
    logic [11:0] f;
    int n;
    build(v, n9, f, n);
    expq.push_back(f);
    nq.push_back(n);
    @(negedge clk);
    tx_data = v;
    b9 = n9;
    tx_write = 1'b1;
    @(negedge clk);
    tx_write = 1'b0;
  endtask : wr
  task automatic rx_tx(input int k);
    repeat (k) begin
      u_peer.recv(got, nq.pop_front());
      chk(got, expq.pop_front(), "tx frame");
    end
    @(negedge clk);
  endtask : rx_tx
  task automatic rx_one(input logic [7:0] v, input logic n9, logic [11:0] x);
    logic [11:0] f;
    int n;
    build(v, n9, f, n);
    u_peer.send(f ^ x, n, 16);
  endtask : rx_one
  task automatic rd_clr;
    @(negedge clk);
    rx_read = 1'b1;
    err_clr = 1'b1;
    @(negedge clk);
    rx_read = 1'b0;
    err_clr = 1'b0;
  endtask : rd_clr
  initial begin
    {arst_n, par, odd, stop2, atn, diag, flow, msm} = 8'h00;
    {tx_write, b9, rx_read, aws, err_clr} = 5'h00;
    {psc, div, fmt, spos, tx_data, irq_en} = {5'h01, 11'h000, 15'h0001};
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    chk({txd, rts_n, empty, full, busy, irq}, 6'h39, "reset");
    for (int c = 0; c < 4; c++) begin
      {fmt, par, odd, stop2} = cfg[c];
      wr(8'($random(seed)), 1'b1);
      for (int t = 0; t < 400 && empty !== 1'b1; t++) @(negedge clk);
      wr(8'($random(seed)), 1'b0);
      rx_tx(2);
      chk(busy, 1'b1, "busy in stop");
      repeat (12) @(negedge clk);
      chk(busy, 1'b0, "busy after");
      d = 8'($random(seed));
      rx_one(d, 1'b1, 12'h000);
      chk({rbuf, r9, full, pe, fe}, {fmt == 2'd0 ? {1'b0, d[6:0]} : d,
          fmt[1], 3'b100}, "rx frame");
      rd_clr;
      chk(full, 1'b0, "read clears");
      pos = (fmt == 2'd0 ? 7 : 8) + fmt[1];
      rx_one(d, 1'b0, 12'h001 << pos);
      chk({pe, fe}, {par, !par}, "bad frame");
      rd_clr;
      $display("format %0d done", c);
    end
    u_peer.send(12'h000, 0, 5);
    repeat (300) @(negedge clk);
    chk(full, 1'b0, "glitch");
    rx_one(8'h5a, 1'b0, 12'h000);
    rx_one(8'ha5, 1'b0, 12'h000);
    chk(oe, 1'b1, "overrun");
    rd_clr;
    u_peer.send(12'h000, 0, 384);
    chk(brk, 1'b1, "break");
    rd_clr;
    atn = 1'b1;
    @(negedge clk);
    aws = 1'b1;
    @(negedge clk);
    aws = 1'b0;
    rx_one(8'h33, 1'b0, 12'h000);
    chk(full, 1'b0, "data dropped");
    rx_one(8'h81, 1'b1, 12'h000);
    chk({rbuf, r9, full, awb}, {8'h81, 3'b110}, "address");
    rd_clr;
    rx_one(8'h42, 1'b0, 12'h000);
    chk({rbuf, full}, {8'h42, 1'b1}, "after address");
    rd_clr;
    atn = 1'b0;
    $display("attention done");
    msm = 1'b1;
    spos = 4'h5;
    d = 8'($random(seed));
    rx_one(d, 1'b0, 12'h000);
    chk({rbuf, full}, {d, 1'b1}, "manual sample");
    rd_clr;
    msm = 1'b0;
    diag = 1'b1;
    d = 8'($random(seed));
    wr(d, 1'b1);
    for (int t = 0; t < 600 && full !== 1'b1; t++) @(negedge clk);
    chk({rbuf, r9, full}, {d, 2'b11}, "loopback");
    rd_clr;
    diag = 1'b0;
    expq.delete();
    nq.delete();
    flow = 1'b1;
    u_peer.hold(1'b1);
    wr(8'($random(seed)), 1'b0);
    repeat (100) @(negedge clk);
    chk({txd, rts_n, irq}, 3'b100, "cts held");
    u_peer.hold(1'b0);
    rx_tx(1);
    flow = 1'b0;
    irq_en = 1'b0;
    @(negedge clk);
    chk(irq, 1'b0, "irq masked");
    $display("flow done");
    close_out;
  end
endmodule : test_async_serial_transceiver
`default_nettype wire
